// ---- include/fault_pkg.sv ----
// Constants, register map, field positions and types of the fault supervisor.
// Assumes a single 250 MHz clock shared by every module that uses it.
`default_nettype none
package fault_pkg;
    localparam int unsigned CLK_MHZ       = 250;
    localparam int unsigned TXD_DOM_MS    = 1000;
    localparam int unsigned NR_TIMEOUT_MS = 150;
    localparam int unsigned TXD_DOM_CYCLES = TXD_DOM_MS * 1000 * CLK_MHZ;
    localparam int unsigned NR_TIMEOUT_CYCLES =
        NR_TIMEOUT_MS * 1000 * CLK_MHZ;
    localparam int TMR_W  = 28;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    localparam logic [3:0] ADR_SUPPLY = 4'h0;
    localparam logic [3:0] ADR_HS_ST  = 4'h1;
    localparam logic [3:0] ADR_BUS_ST = 4'h2;
    localparam logic [3:0] ADR_WD_ST  = 4'h3;
    localparam logic [3:0] ADR_SRC    = 4'h4;
    localparam logic [3:0] ADR_IRQ_ST = 4'h5;
    localparam logic [3:0] ADR_MASK   = 4'h6;
    localparam logic [3:0] ADR_MODE   = 4'h7;
    localparam logic [3:0] ADR_HS_CTL = 4'h8;

    localparam int SUP_OV_BIT   = 3;
    localparam int SUP_UV_BIT   = 2;
    localparam int SUP_WARN_BIT = 1;
    localparam int SUP_BAT_BIT  = 0;
    localparam int BUS_RXS_BIT  = 3;
    localparam int BUS_TXD_BIT  = 2;
    localparam int BUS_HOT_BIT  = 1;
    localparam int WD_TO_BIT    = 3;
    localparam int WD_ERR_BIT   = 2;
    localparam int HS2_OL_BIT   = 3;
    localparam int HS2_CL_BIT   = 2;
    localparam int HS1_OL_BIT   = 1;
    localparam int HS1_CL_BIT   = 0;
    localparam int IRQ_SUP_BIT  = 0;
    localparam int IRQ_BUS_BIT  = 1;
    localparam int IRQ_HS_BIT   = 2;
    localparam int HIGH_VOLTAGE_SHUTDOWN_ENABLE_BIT     = 0;

    localparam logic [3:0] SRC_NONE   = 4'h0;
    localparam logic [3:0] SRC_HS     = 4'h2;
    localparam logic [3:0] SRC_BUS    = 4'h4;
    localparam logic [3:0] SRC_SUPPLY = 4'h5;

    localparam logic [2:0] MASK_RST   = 3'h0;
    localparam logic [1:0] HS_CTL_RST = 2'h0;
    localparam logic       HIGH_VOLTAGE_SHUTDOWN_ENABLE_RST   = 1'h0;

    // Index of each comparator input in the synchronised vector.
    localparam int S_VS_OV    = 0;
    localparam int S_VS_UV    = 1;
    localparam int S_BAT      = 2;
    localparam int S_VDD_WARN = 3;
    localparam int S_VDD_HOT  = 4;
    localparam int S_VDD_UV   = 5;
    localparam int S_RXS      = 6;
    localparam int S_TXD      = 7;
    localparam int S_LIN_HOT  = 8;
    localparam int S_HS_HOT   = 9;
    localparam int S_HS1_OL   = 10;
    localparam int S_HS2_OL   = 11;
    localparam int S_HS1_CL   = 12;
    localparam int S_HS2_CL   = 13;
    localparam int S_WD_FLOAT = 14;
    localparam int SYNC_W     = 15;

    typedef enum logic [2:0] {
        MODE_RESET, MODE_NORMAL_REQUEST, MODE_NORMAL, MODE_STOP, MODE_SLEEP
    } mode_t;

    typedef enum logic [1:0] {HOT_IDLE, HOT_RESET, HOT_SLEEP} hot_state_t;

    function automatic logic is_active(input mode_t m);
        return (m == MODE_NORMAL) || (m == MODE_NORMAL_REQUEST);
    endfunction

    function automatic logic is_irq_mode(input mode_t m);
        return is_active(m) || (m == MODE_STOP);
    endfunction

    function automatic logic is_low_power(input mode_t m);
        return (m == MODE_STOP) || (m == MODE_SLEEP);
    endfunction
endpackage
`default_nettype wire

// ---- core/sync2.sv ----
// Two-flop synchroniser for a vector of independent level inputs.
// Assumes each bit is a slow level; bits are not coherent with each other.
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
    parameter int W = fault_pkg::SYNC_W
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] held;
    } sync_state_t;

    sync_state_t st_ff;
    sync_state_t nxt_st;

    always_comb begin
        nxt_st      = st_ff;
        nxt_st.meta = d;
        nxt_st.held = st_ff.meta;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.held;
endmodule
`default_nettype wire

// ---- core/stuck_timer.sv ----
// Counts cycles while run is high and pulses expired once at LIMIT.
// Assumes run comes from the same clock domain; dropping run restarts it.
`timescale 1ns/10ps
`default_nettype none
module stuck_timer #(
    parameter logic [fault_pkg::TMR_W-1:0] LIMIT =
        fault_pkg::TMR_W'(fault_pkg::NR_TIMEOUT_CYCLES)
) (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic run,
    output var  logic expired
);
    typedef struct packed {
        logic [fault_pkg::TMR_W-1:0] cnt;
        logic                        hit;
    } tmr_state_t;

    tmr_state_t st_ff;
    tmr_state_t nxt_st;

    // The count saturates so that a held condition fires only once.
    always_comb begin
        nxt_st     = st_ff;
        nxt_st.hit = 1'h0;
        if (!run) begin
            nxt_st.cnt = '0;
        end else if (st_ff.cnt != LIMIT) begin
            nxt_st.cnt = st_ff.cnt + 1'h1;
            nxt_st.hit = (nxt_st.cnt == LIMIT);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign expired = st_ff.hit;

    chk_expire_at_limit: assert property (
        @(posedge clk) disable iff (srst) st_ff.hit |-> st_ff.cnt == LIMIT)
        else $error("timer pulse without full count");
endmodule
`default_nettype wire

// ---- core/fault_supervisor.sv ----
// Fault supervisor: flags, shutdown controls, resets and interrupt line.
// Assumes comparator inputs are asynchronous levels and that mode, the
// watchdog events and the register port run on clk.
//
// Functional notes
// - Overvoltage sets supply flag in active modes; shuts drivers in Normal if enabled.
// - Regulator hot warning flag follows condition outside low power; irq.
// - Regulator overheat disables regulator, issues reset, then asks Sleep.
// - Receive short disables transmitter and sets flag until recovered.
// - Transmit input low over one second disables transmitter, irq.
// - High-side overheat in active modes latches drivers off, all flags set, irq.
// - Open load sets per-driver flag without interrupt.
// - Current limit sets per-driver flag, driver stays on.
// - Normal Request lasting 150 ms issues a reset, unrecorded.
// - Watchdog fault in Normal resets and sets timeout flag.
// - Floating watchdog pin selects internal timebase and sets error flag.
// - In Reset mode, regulator low without supply undervolt asks Sleep.
// - Interrupts only in Normal, Normal Request and Stop modes.
// - Masked faults leave line high and set no source flag.
// - Bus status read without short clears receive short flag.
// - Bus status read with transmit input high clears dominant flag.
`timescale 1ns/10ps
`default_nettype none
module fault_supervisor #(
    parameter logic [fault_pkg::TMR_W-1:0] TXD_DOM_CYCLES =
        fault_pkg::TMR_W'(fault_pkg::TXD_DOM_CYCLES),
    parameter logic [fault_pkg::TMR_W-1:0] NR_TIMEOUT_CYCLES =
        fault_pkg::TMR_W'(fault_pkg::NR_TIMEOUT_CYCLES)
) (
    input  wire logic                          clk,
    input  wire logic                          srst,
    input  wire logic [fault_pkg::ADDR_W-1:0]  addr,
    input  wire logic [fault_pkg::DATA_W-1:0]  wdata,
    input  wire logic                          wr_en,
    input  wire logic                          rd_en,
    output var  logic [fault_pkg::DATA_W-1:0]  rdata,
    input  wire fault_pkg::mode_t              mode,
    input  wire logic                          vs_ov_in,
    input  wire logic                          vs_uv_in,
    input  wire logic                          bat_fail_in,
    input  wire logic                          vdd_warn_in,
    input  wire logic                          vdd_hot_in,
    input  wire logic                          vdd_uv_in,
    input  wire logic                          rxd_short_in,
    input  wire logic                          txd_in,
    input  wire logic                          lin_hot_in,
    input  wire logic                          hs_hot_in,
    input  wire logic                          hs1_open_in,
    input  wire logic                          hs2_open_in,
    input  wire logic                          hs1_limit_in,
    input  wire logic                          hs2_limit_in,
    input  wire logic                          wd_conf_float_in,
    input  wire logic                          wd_timeout,
    input  wire logic                          wd_clear_closed,
    output var  logic                          irq_n,
    output var  logic [1:0]                    hs_drive,
    output var  logic                          lin_tx_enable,
    output var  logic                          reset_req,
    output var  logic                          sleep_req,
    output var  logic                          vdd_enable,
    output var  logic                          wd_internal_timebase
);
    typedef struct packed {
        logic [7:0]            rdata;
        logic                  irq_n;
        logic [1:0]            hs_drive;
        logic                  tx_en;
        logic                  rst_req;
        logic                  sleep_req;
        logic                  vdd_en;
        logic                  wd_int;
        logic [3:0]            sup;
        logic [3:0]            bus;
        logic [3:0]            wd;
        logic [3:0]            hs;
        logic [2:0]            irq_stat;
        logic [2:0]            irq_mask;
        logic                  high_voltage_shutdown_enable;
        logic [1:0]            hs_ctl;
        logic                  hv_off;
        logic                  hot_off;
        logic                  tx_off;
        fault_pkg::hot_state_t hot;
    } sup_state_t;

    sup_state_t                   st_ff;
    sup_state_t                   nxt_st;
    logic [fault_pkg::SYNC_W-1:0] raw;
    logic [fault_pkg::SYNC_W-1:0] cmp;
    logic                         txd_stuck;
    logic                         nr_expired;
    logic                         act;
    logic                         irqm;
    logic                         wd_ev;
    logic                         bus_rd;
    logic                         wd_rd;
    logic [2:0]                   ev;

    always_comb begin
        raw                        = '0;
        raw[fault_pkg::S_VS_OV]    = vs_ov_in;
        raw[fault_pkg::S_VS_UV]    = vs_uv_in;
        raw[fault_pkg::S_BAT]      = bat_fail_in;
        raw[fault_pkg::S_VDD_WARN] = vdd_warn_in;
        raw[fault_pkg::S_VDD_HOT]  = vdd_hot_in;
        raw[fault_pkg::S_VDD_UV]   = vdd_uv_in;
        raw[fault_pkg::S_RXS]      = rxd_short_in;
        raw[fault_pkg::S_TXD]      = txd_in;
        raw[fault_pkg::S_LIN_HOT]  = lin_hot_in;
        raw[fault_pkg::S_HS_HOT]   = hs_hot_in;
        raw[fault_pkg::S_HS1_OL]   = hs1_open_in;
        raw[fault_pkg::S_HS2_OL]   = hs2_open_in;
        raw[fault_pkg::S_HS1_CL]   = hs1_limit_in;
        raw[fault_pkg::S_HS2_CL]   = hs2_limit_in;
        raw[fault_pkg::S_WD_FLOAT] = wd_conf_float_in;
    end

    // A one-cycle comparator glitch is not absorbed here; it reaches state three cycles later.
    sync2 #(.W(fault_pkg::SYNC_W)) u_sync (
        .clk  (clk),
        .srst (srst),
        .d    (raw),
        .q    (cmp)
    );

    stuck_timer #(.LIMIT(TXD_DOM_CYCLES)) u_txd_timer (
        .clk     (clk),
        .srst    (srst),
        .run     (!cmp[fault_pkg::S_TXD]),
        .expired (txd_stuck)
    );

    stuck_timer #(.LIMIT(NR_TIMEOUT_CYCLES)) u_nr_timer (
        .clk     (clk),
        .srst    (srst),
        .run     (mode == fault_pkg::MODE_NORMAL_REQUEST),
        .expired (nr_expired)
    );

    always_comb begin
        nxt_st = st_ff;
        act    = fault_pkg::is_active(mode);
        irqm   = fault_pkg::is_irq_mode(mode);
        bus_rd = rd_en && (addr == fault_pkg::ADR_BUS_ST);
        wd_rd  = rd_en && (addr == fault_pkg::ADR_WD_ST);
        wd_ev  = (wd_timeout || wd_clear_closed)
                 && (mode == fault_pkg::MODE_NORMAL);

        // Supply flags are levels: they drop as soon as the condition goes.
        nxt_st.sup[fault_pkg::SUP_OV_BIT] =
            cmp[fault_pkg::S_VS_OV] && act;
        nxt_st.sup[fault_pkg::SUP_UV_BIT]  = cmp[fault_pkg::S_VS_UV];
        nxt_st.sup[fault_pkg::SUP_BAT_BIT] = cmp[fault_pkg::S_BAT];
        nxt_st.sup[fault_pkg::SUP_WARN_BIT] = cmp[fault_pkg::S_VDD_WARN]
            && !fault_pkg::is_low_power(mode);

        // Sticky receive short and dominant flags: set is applied after clear so set wins.
        nxt_st.bus[fault_pkg::BUS_HOT_BIT] = cmp[fault_pkg::S_LIN_HOT];
        if (bus_rd && !cmp[fault_pkg::S_RXS]) begin
            nxt_st.bus[fault_pkg::BUS_RXS_BIT] = 1'h0;
        end
        if (cmp[fault_pkg::S_RXS]) begin
            nxt_st.bus[fault_pkg::BUS_RXS_BIT] = 1'h1;
        end
        if (bus_rd && cmp[fault_pkg::S_TXD]) begin
            nxt_st.bus[fault_pkg::BUS_TXD_BIT] = 1'h0;
        end
        if (txd_stuck) begin
            nxt_st.bus[fault_pkg::BUS_TXD_BIT] = 1'h1;
        end
        if (!cmp[fault_pkg::S_RXS] && !cmp[fault_pkg::S_LIN_HOT]
            && cmp[fault_pkg::S_TXD]) begin
            nxt_st.tx_off = 1'h0;
        end
        if (cmp[fault_pkg::S_RXS] || cmp[fault_pkg::S_LIN_HOT]
            || txd_stuck) begin
            nxt_st.tx_off = 1'h1;
        end
        nxt_st.tx_en = !nxt_st.tx_off;

        // Watchdog status.
        nxt_st.wd[fault_pkg::WD_ERR_BIT] = cmp[fault_pkg::S_WD_FLOAT];
        nxt_st.wd_int = cmp[fault_pkg::S_WD_FLOAT];
        if (wd_rd) begin
            nxt_st.wd[fault_pkg::WD_TO_BIT] = 1'h0;
        end
        if (wd_ev) begin
            nxt_st.wd[fault_pkg::WD_TO_BIT] = 1'h1;
        end

        // High-side control; a latch is released only once its cause left.
        if (wr_en && (addr == fault_pkg::ADR_HS_CTL)) begin
            nxt_st.hs_ctl = wdata[1:0];
            if (!cmp[fault_pkg::S_HS_HOT]) begin
                nxt_st.hot_off = 1'h0;
            end
            if (!cmp[fault_pkg::S_VS_OV]) begin
                nxt_st.hv_off = 1'h0;
            end
        end
        if (act && cmp[fault_pkg::S_HS_HOT]) begin
            nxt_st.hot_off = 1'h1;
        end
        if ((mode == fault_pkg::MODE_NORMAL) && cmp[fault_pkg::S_VS_OV]
            && st_ff.high_voltage_shutdown_enable) begin
            nxt_st.hv_off = 1'h1;
        end
        if (nxt_st.hot_off) begin
            nxt_st.hs = 4'hF;
        end else begin
            nxt_st.hs[fault_pkg::HS1_OL_BIT] = cmp[fault_pkg::S_HS1_OL];
            nxt_st.hs[fault_pkg::HS2_OL_BIT] = cmp[fault_pkg::S_HS2_OL];
            nxt_st.hs[fault_pkg::HS1_CL_BIT] = cmp[fault_pkg::S_HS1_CL];
            nxt_st.hs[fault_pkg::HS2_CL_BIT] = cmp[fault_pkg::S_HS2_CL];
        end
        // Current limiting is handled in the driver; it stays switched on.
        nxt_st.hs_drive = nxt_st.hs_ctl
                          & ~{2{nxt_st.hot_off || nxt_st.hv_off}};

        // Interrupt events are new flags; battery fail, open load and limit raise none.
        ev                        = '0;
        ev[fault_pkg::IRQ_SUP_BIT] =
            |(nxt_st.sup[3:1] & ~st_ff.sup[3:1]);
        ev[fault_pkg::IRQ_BUS_BIT] =
            |(nxt_st.bus[3:1] & ~st_ff.bus[3:1]);
        ev[fault_pkg::IRQ_HS_BIT]  = nxt_st.hot_off && !st_ff.hot_off;
        if (wr_en && (addr == fault_pkg::ADR_IRQ_ST)) begin
            nxt_st.irq_stat = st_ff.irq_stat & ~wdata[2:0];
        end
        nxt_st.irq_stat = nxt_st.irq_stat
                          | (ev & st_ff.irq_mask & {3{irqm}});
        if (wr_en && (addr == fault_pkg::ADR_MASK)) begin
            nxt_st.irq_mask = wdata[2:0];
        end
        if (wr_en && (addr == fault_pkg::ADR_MODE)) begin
            nxt_st.high_voltage_shutdown_enable = wdata[fault_pkg::HIGH_VOLTAGE_SHUTDOWN_ENABLE_BIT];
        end
        nxt_st.irq_n = !(|(nxt_st.irq_stat & nxt_st.irq_mask));

        // Regulator overheat sequence: reset first, then hold Sleep request.
        case (st_ff.hot)
            fault_pkg::HOT_IDLE: begin
                if (cmp[fault_pkg::S_VDD_HOT]) begin
                    nxt_st.hot = fault_pkg::HOT_RESET;
                end
            end
            fault_pkg::HOT_RESET: begin
                nxt_st.hot = fault_pkg::HOT_SLEEP;
            end
            fault_pkg::HOT_SLEEP: begin
                if ((mode == fault_pkg::MODE_SLEEP)
                    && !cmp[fault_pkg::S_VDD_HOT]) begin
                    nxt_st.hot = fault_pkg::HOT_IDLE;
                end
            end
            default: begin
                nxt_st.hot = fault_pkg::HOT_IDLE;
            end
        endcase
        nxt_st.vdd_en = (nxt_st.hot == fault_pkg::HOT_IDLE);
        nxt_st.rst_req = (nxt_st.hot == fault_pkg::HOT_RESET)
                         || nr_expired
                         || wd_ev;
        nxt_st.sleep_req = (nxt_st.hot == fault_pkg::HOT_SLEEP)
            || ((mode == fault_pkg::MODE_RESET) && cmp[fault_pkg::S_VDD_UV]
                && !st_ff.sup[fault_pkg::SUP_UV_BIT]);

        nxt_st.rdata = '0;
        if (rd_en) begin
            case (addr)
                fault_pkg::ADR_SUPPLY: nxt_st.rdata = {4'h0, st_ff.sup};
                fault_pkg::ADR_HS_ST:  nxt_st.rdata = {4'h0, st_ff.hs};
                fault_pkg::ADR_BUS_ST: nxt_st.rdata = {4'h0, st_ff.bus};
                fault_pkg::ADR_WD_ST:  nxt_st.rdata = {4'h0, st_ff.wd};
                fault_pkg::ADR_SRC: begin
                    if (st_ff.irq_stat[fault_pkg::IRQ_HS_BIT]) begin
                        nxt_st.rdata = {4'h0, fault_pkg::SRC_HS};
                    end else if (st_ff.irq_stat[fault_pkg::IRQ_BUS_BIT]) begin
                        nxt_st.rdata = {4'h0, fault_pkg::SRC_BUS};
                    end else if (st_ff.irq_stat[fault_pkg::IRQ_SUP_BIT]) begin
                        nxt_st.rdata = {4'h0, fault_pkg::SRC_SUPPLY};
                    end else begin
                        nxt_st.rdata = {4'h0, fault_pkg::SRC_NONE};
                    end
                end
                fault_pkg::ADR_IRQ_ST: nxt_st.rdata = {5'h00, st_ff.irq_stat};
                fault_pkg::ADR_MASK:   nxt_st.rdata = {5'h00, st_ff.irq_mask};
                fault_pkg::ADR_MODE:   nxt_st.rdata = {7'h00, st_ff.high_voltage_shutdown_enable};
                fault_pkg::ADR_HS_CTL: nxt_st.rdata = {6'h00, st_ff.hs_ctl};
                default:               nxt_st.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_ff          <= '0;
            st_ff.irq_n    <= 1'h1;
            st_ff.tx_en    <= 1'h1;
            st_ff.vdd_en   <= 1'h1;
            st_ff.irq_mask <= fault_pkg::MASK_RST;
            st_ff.hs_ctl   <= fault_pkg::HS_CTL_RST;
            st_ff.high_voltage_shutdown_enable     <= fault_pkg::HIGH_VOLTAGE_SHUTDOWN_ENABLE_RST;
            st_ff.hot      <= fault_pkg::HOT_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rdata                = st_ff.rdata;
    assign irq_n                = st_ff.irq_n;
    assign hs_drive             = st_ff.hs_drive;
    assign lin_tx_enable        = st_ff.tx_en;
    assign reset_req            = st_ff.rst_req;
    assign sleep_req            = st_ff.sleep_req;
    assign vdd_enable           = st_ff.vdd_en;
    assign wd_internal_timebase = st_ff.wd_int;

    chk_overvolt_flag: assert property (
        @(posedge clk) disable iff (srst)
        (cmp[fault_pkg::S_VS_OV] && act) |=>
        st_ff.sup[fault_pkg::SUP_OV_BIT])
        else $error("overvoltage flag not set");
    chk_hv_shutdown: assert property (
        @(posedge clk) disable iff (srst)
        (mode == fault_pkg::MODE_NORMAL && st_ff.high_voltage_shutdown_enable
         && cmp[fault_pkg::S_VS_OV]) |=> hs_drive == 2'h0)
        else $error("drivers on during overvoltage");
    chk_hot_sequence: assert property (
        @(posedge clk) disable iff (srst)
        (st_ff.hot == fault_pkg::HOT_IDLE && cmp[fault_pkg::S_VDD_HOT]) |=>
        (reset_req && !vdd_enable) ##1 (sleep_req && !vdd_enable))
        else $error("overheat reset then sleep missing");
    chk_short_tx_off: assert property (
        @(posedge clk) disable iff (srst)
        cmp[fault_pkg::S_RXS] |=> !lin_tx_enable
        && st_ff.bus[fault_pkg::BUS_RXS_BIT])
        else $error("transmitter on during receive short");
    chk_dominant_flag: assert property (
        @(posedge clk) disable iff (srst)
        txd_stuck |=> st_ff.bus[fault_pkg::BUS_TXD_BIT] && !lin_tx_enable)
        else $error("dominant timeout not handled");
    chk_hs_hot_off: assert property (
        @(posedge clk) disable iff (srst)
        (act && cmp[fault_pkg::S_HS_HOT]) |=>
        (hs_drive == 2'h0 && st_ff.hs == 4'hF))
        else $error("high-side overheat not handled");
    chk_wd_reset: assert property (
        @(posedge clk) disable iff (srst)
        wd_ev |=> reset_req && st_ff.wd[fault_pkg::WD_TO_BIT])
        else $error("watchdog fault without reset");
    chk_reset_sleep: assert property (
        @(posedge clk) disable iff (srst)
        (mode == fault_pkg::MODE_RESET && cmp[fault_pkg::S_VDD_UV]
         && !st_ff.sup[fault_pkg::SUP_UV_BIT]) |=> sleep_req)
        else $error("reset mode undervoltage without sleep");
    chk_irq_modes: assert property (
        @(posedge clk) disable iff (srst)
        !irqm |=> (st_ff.irq_stat & ~$past(st_ff.irq_stat)) == 3'h0)
        else $error("interrupt set in a quiet mode");
    chk_mask_holds: assert property (
        @(posedge clk) disable iff (srst)
        (st_ff.irq_stat & ~$past(st_ff.irq_stat)
         & ~$past(st_ff.irq_mask)) == 3'h0)
        else $error("masked fault set a source flag");
endmodule
`default_nettype wire

// ---- tb/host_model.sv ----
// Host model: the microcontroller side of the register port.
// Assumes one clock; it moves strobes only right after rising edges.
`timescale 1ns/10ps
`default_nettype none
module host_model (
    input  wire logic       clk,
    output var  logic [3:0] addr = 4'h0,
    output var  logic [7:0] wdata = 8'h00,
    output var  logic       wr_en = 1'b0,
    output var  logic       rd_en = 1'b0,
    input  wire logic [7:0] rdata
);
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        wdata <= ~v;
        #1;
    endtask
    // Read data live only in the cycle after the strobe, so take it then.
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        v = rdata;
    endtask
endmodule
`default_nettype wire

// ---- tb/tb_fault_supervisor.sv ----
// Testbench of the fault supervisor: flags, shutdowns and interrupt line.
// Assumes host_model owns the register port; timer counts are shortened.
`timescale 1ns/10ps
`default_nettype none
module tb_fault_supervisor;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [14:0] c = 15'h0080;
    logic wdt = 1'b0;
    fault_pkg::mode_t mode = fault_pkg::MODE_NORMAL;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, d;
    logic wr_en, rd_en, irq_n, tx_en, rst_req;
    logic [1:0] hs;
    logic slp, vdd_en, wdi, wcc = 1'b0;
    int n_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int k = 0;
    fault_supervisor #(.TXD_DOM_CYCLES(28'h14), .NR_TIMEOUT_CYCLES(28'h1E))
    i_dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .mode(mode),
        .vs_ov_in(c[0]), .vs_uv_in(c[1]), .bat_fail_in(c[2]),
        .vdd_warn_in(c[3]), .vdd_hot_in(c[4]), .vdd_uv_in(c[5]),
        .rxd_short_in(c[6]), .txd_in(c[7]), .lin_hot_in(c[8]),
        .hs_hot_in(c[9]), .hs1_open_in(c[10]), .hs2_open_in(c[11]),
        .hs1_limit_in(c[12]), .hs2_limit_in(c[13]),
        .wd_conf_float_in(c[14]), .wd_timeout(wdt), .wd_clear_closed(wcc),
        .irq_n(irq_n), .hs_drive(hs), .lin_tx_enable(tx_en),
        .reset_req(rst_req), .sleep_req(slp), .vdd_enable(vdd_en),
        .wd_internal_timebase(wdi));
    host_model h (.clk(clk), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata));
    initial forever #2 clk = ~clk;
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            n_errors++;
            $display("wrong value at %0t: %h not %h", $time, s, e);
        end
    endtask
    // Waiting past the edge keeps checks clear of same-step updates.
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic results();
        $display("%0d checks, %0d errors", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            results();
        end
    end
    task automatic t_warn();
        h.rd(4'h6, d);
        chk(d, 8'h00);
        h.rd(4'h9, d);
        chk(d, 8'h00);
        h.wr(4'h6, 8'h07);
        @(posedge clk) c[3] <= 1'b1;
        w(5);
        chk(irq_n, 1'b0);
        h.rd(4'h4, d);
        chk(d, 8'h05);
        @(posedge clk) c[3] <= 1'b0;
        w(5);
        h.wr(4'h5, 8'h07);
        chk(irq_n, 1'b1);
        h.rd(4'h0, d);
        chk(d, 8'h00);
        $display("warning test done");
    endtask
    task automatic t_txd();
        @(posedge clk) c[7] <= 1'b0;
        w(30);
        chk(tx_en, 1'b0);
        chk(irq_n, 1'b0);
        h.rd(4'h2, d);
        chk(d, 8'h04);
        @(posedge clk) c[7] <= 1'b1;
        w(5);
        h.rd(4'h2, d);
        chk(d, 8'h04);
        h.rd(4'h2, d);
        chk(d, 8'h00);
        chk(tx_en, 1'b1);
        @(posedge clk) c[6] <= 1'b1;
        w(4);
        chk(tx_en, 1'b0);
        @(posedge clk) c[6] <= 1'b0;
        w(4);
        h.rd(4'h2, d);
        chk(d, 8'h08);
        h.rd(4'h2, d);
        chk(d, 8'h00);
        h.wr(4'h5, 8'h07);
        $display("transmit test done");
    endtask
    task automatic t_hot();
        h.wr(4'h6, 8'h03);
        h.wr(4'h8, 8'h03);
        @(posedge clk) c[13:10] <= 4'h9;
        w(5);
        h.rd(4'h1, d);
        chk(d, 8'h06);
        chk(hs, 2'h3);
        chk(irq_n, 1'b1);
        @(posedge clk) c[13:9] <= 5'h01;
        w(5);
        chk(hs, 2'h0);
        chk(irq_n, 1'b1);
        h.rd(4'h1, d);
        chk(d, 8'h0F);
        @(posedge clk) c[9] <= 1'b0;
        w(5);
        chk(hs, 2'h0);
        h.wr(4'h8, 8'h03);
        chk(hs, 2'h3);
        h.wr(4'h7, 8'h01);
        @(posedge clk) c[0] <= 1'b1;
        w(4);
        chk(hs, 2'h0);
        h.rd(4'h0, d);
        chk(d, 8'h08);
        @(posedge clk) c[0] <= 1'b0;
        w(4);
        h.wr(4'h8, 8'h03);
        chk(hs, 2'h3);
        $display("high side test done");
    endtask
    task automatic t_nr();
        @(posedge clk) mode <= fault_pkg::MODE_NORMAL_REQUEST;
        repeat (40) begin
            w(1);
            k += (rst_req === 1'b1);
        end
        chk(k, 8'h01);
        @(posedge clk) mode <= fault_pkg::MODE_NORMAL;
        h.rd(4'h3, d);
        chk(d, 8'h00);
        @(posedge clk) wdt <= 1'b1;
        @(posedge clk) wdt <= 1'b0;
        #1 chk(rst_req, 1'b1);
        h.rd(4'h3, d);
        chk(d, 8'h08);
        @(posedge clk) wcc <= 1'b1;
        @(posedge clk) wcc <= 1'b0;
        #1 chk(rst_req, 1'b1);
        h.rd(4'h3, d);
        chk(d, 8'h08);
        $display("timeout test done");
    endtask
    task automatic t_vdd();
        @(posedge clk) c <= 15'h4090;
        w(3);
        chk({wdi, rst_req, vdd_en, slp}, 8'h0C);
        w(1);
        chk({rst_req, vdd_en, slp}, 8'h01);
        h.rd(4'h3, d);
        chk(d, 8'h04);
        @(posedge clk) mode <= fault_pkg::MODE_SLEEP;
        c <= 15'h4080;
        w(5);
        chk({vdd_en, slp}, 8'h02);
        @(posedge clk) mode <= fault_pkg::MODE_RESET;
        c <= 15'h40A0;
        w(4);
        chk(slp, 1'b1);
        $display("regulator test done");
    endtask
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        t_warn();
        t_txd();
        t_hot();
        t_nr();
        t_vdd();
        results();
    end
endmodule
`default_nettype wire
